// >>> hw/rsm_top.sv
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`include "rsm_defs.svh"

module rsm_top
  import rsm_pkg::*;
#(
  parameter int unsigned DLY_LO_CYC = `RSM_DLY_LO_MS * `RSM_MS_CYC,
  parameter int unsigned DLY_MID_CYC = `RSM_DLY_MID_MS * `RSM_MS_CYC,
  parameter int unsigned DLY_HI_CYC = `RSM_DLY_HI_MS * `RSM_MS_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  // analog comparators
  input wire logic bat_above_por,
  input wire rsm_lvl_t bat_level,
  input wire logic core_above_rst,
  input wire logic core_above_warn,
  // other reset requests as one-cycle pulses, and the sleep_mode level
  input wire logic other_rst_req,
  input wire logic flash_prog_req,
  input wire logic sleep_mode,
  // axi4-lite slave
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // to the rest of the chip
  output logic sys_reset,
  output logic rst_pin_n_o,
  output logic rst_pin_n_oe,
  output logic core_halt,
  output logic [15:0] program_counter,
  output logic sp_reinit,
  output logic ram_invalid,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic irq_timer_disable,
  output logic int_osc_sel,
  output logic wdt_enable,
  output logic wdt_tick,
  output logic warn_irq
);

  typedef struct packed {
    rsm_state_t st;
    logic [`RSM_CNT_W-1:0] cnt;
    logic por_cause;
    logic mon_en;
    logic mon_sel;
    logic pin_drive;
    logic ram_bad;
    logic [3:0] wdt_div;
    logic wdt_tick;
    logic wdt_en;
    logic warn_prev;
    logic warn_irq;
    logic sys_reset;
    logic aw_got;
    logic [3:0] aw_adr;
    logic w_got;
    logic [31:0] w_dat;
    logic [3:0] w_stb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsm_state_s_t;

  rsm_state_s_t q;
  rsm_state_s_t d;

  logic mon_live;
  logic mon_fail;
  logic flash_err;
  logic wr_go;
  logic [`RSM_CNT_W-1:0] dly_cyc;

  // --------------------------------------------------------------------
  // reset sources
  // --------------------------------------------------------------------
  // sleep gates the monitor off without touching the stored enable bits
  assign mon_live = q.mon_en & q.mon_sel & ~sleep_mode;
  assign mon_fail = mon_live & ~core_above_rst;
  assign flash_err = flash_prog_req & ~q.mon_en;
  assign wr_go = q.aw_got & q.w_got & ~q.bvalid;

  always_comb
  begin
    unique case (bat_level)
      RSM_LVL_LO: dly_cyc = `RSM_CNT_W'(DLY_LO_CYC);
      RSM_LVL_MID: dly_cyc = `RSM_CNT_W'(DLY_MID_CYC);
      default: dly_cyc = `RSM_CNT_W'(DLY_HI_CYC);
    endcase
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.wdt_tick = 1'b0;
    // early warning: event when supply drops below warning level
    d.warn_prev = core_above_warn;
    d.warn_irq = q.warn_prev & ~core_above_warn;

    unique case (q.st)
      RSM_ST_POR:
      begin
        d.cnt = '0;
        if (bat_above_por)
        begin
          d.st = RSM_ST_DELAY;
        end
      end
      RSM_ST_DELAY:
      begin
        d.cnt = q.cnt + `RSM_CNT_W'(1);
        if (q.cnt + `RSM_CNT_W'(1) >= dly_cyc)
        begin
          d.st = RSM_ST_RUN;
          d.por_cause = 1'b1;
        end
      end
      RSM_ST_HOLD:
      begin
        // monitor reset: released without any power-on delay
        if (core_above_rst)
        begin
          d.st = RSM_ST_RUN;
        end
      end
      RSM_ST_RUN:
      begin
        if (mon_fail)
        begin
          d.st = RSM_ST_HOLD;
        end
      end
    endcase

    // monitor/power-on: restore monitor defaults, cause flag one
    if (q.st != RSM_ST_RUN || mon_fail)
    begin
      d.mon_en = 1'b1;
      d.mon_sel = 1'b1;
      d.por_cause = 1'b1;
      d.ram_bad = 1'b1;
    end
    else if (flash_err || other_rst_req)
    begin
      // other resets keep monitor state, clear cause flag
      d.por_cause = 1'b0;
      d.ram_bad = 1'b0;
    end
    else if (wr_go)
    begin
      if (q.aw_adr == `RSM_ADR_CTRL && q.w_stb[0])
      begin
        d.mon_en = q.w_dat[`RSM_BIT_MEN];
      end
      if (q.aw_adr == `RSM_ADR_CAUSE && q.w_stb[0])
      begin
        // the cause position is write-to-select, read-as-cause
        d.mon_sel = q.w_dat[`RSM_BIT_POR];
        if (q.w_dat[`RSM_BIT_SW])
        begin
          d.por_cause = 1'b0;
          d.ram_bad = 1'b0;
        end
      end
    end

    d.pin_drive = (d.st != RSM_ST_RUN);
    // software reset is a one-cycle internal pulse
    d.sys_reset = (d.st != RSM_ST_RUN) | flash_err | other_rst_req
      | (wr_go && q.aw_adr == `RSM_ADR_CAUSE && q.w_stb[0]
         && q.w_dat[`RSM_BIT_SW]);
    // registered copy so the watchdog enable leaves straight from a flop
    d.wdt_en = ~d.sys_reset;

    // watchdog prescale restarts on every reset
    if (q.sys_reset)
    begin
      d.wdt_div = '0;
    end
    else if (q.wdt_div == `RSM_WDT_DIV - 4'h1)
    begin
      d.wdt_div = '0;
      d.wdt_tick = 1'b1;
    end
    else
    begin
      d.wdt_div = q.wdt_div + 4'h1;
    end

    // axi4-lite write
    if (s_awvalid && !q.aw_got)
    begin
      d.aw_got = 1'b1;
      d.aw_adr = s_awaddr;
    end
    if (s_wvalid && !q.w_got)
    begin
      d.w_got = 1'b1;
      d.w_dat = s_wdata;
      d.w_stb = s_wstrb;
    end
    if (wr_go)
    begin
      d.bvalid = 1'b1;
      d.bresp = (q.aw_adr == `RSM_ADR_CTRL || q.aw_adr == `RSM_ADR_CAUSE
        || q.aw_adr == `RSM_ADR_STAT) ? `RSM_RESP_OK : `RSM_RESP_ERR;
    end
    if (q.bvalid && s_bready)
    begin
      d.bvalid = 1'b0;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
    end

    // axi4-lite read
    if (s_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rdata = '0;
      d.rresp = `RSM_RESP_OK;
      unique case (s_araddr)
        `RSM_ADR_CTRL:
        begin
          d.rdata[`RSM_BIT_MEN] = q.mon_en;
          d.rdata[`RSM_BIT_STAT] = core_above_rst;
          d.rdata[`RSM_BIT_OK] = core_above_warn;
        end
        `RSM_ADR_CAUSE:
        begin
          d.rdata[`RSM_BIT_POR] = q.por_cause;
          d.rdata[`RSM_BIT_FLE] = 1'b0;
        end
        `RSM_ADR_STAT:
        begin
          d.rdata[0] = q.mon_sel;
          d.rdata[1] = q.ram_bad;
        end
        default:
        begin
          d.rresp = `RSM_RESP_ERR;
        end
      endcase
    end
    else if (q.rvalid && s_rready)
    begin
      d.rvalid = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= RSM_ST_POR;
      q.mon_en <= 1'b1;
      q.mon_sel <= 1'b1;
      q.pin_drive <= 1'b1;
      q.sys_reset <= 1'b1;
      q.ram_bad <= 1'b1;
      q.warn_prev <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign sys_reset = q.sys_reset;
  assign rst_pin_n_o = 1'b0;
  assign rst_pin_n_oe = q.pin_drive;
  assign core_halt = q.sys_reset;
  assign program_counter = `RSM_PC_RST;
  assign sp_reinit = q.sys_reset;
  assign ram_invalid = q.ram_bad;
  assign port_latch = `RSM_PORT_RST;
  assign port_open_drain = q.sys_reset;
  assign weak_pullup_en = 1'b1;
  assign irq_timer_disable = q.sys_reset;
  assign int_osc_sel = q.sys_reset;
  assign wdt_enable = q.wdt_en;
  assign wdt_tick = q.wdt_tick;
  assign warn_irq = q.warn_irq;
  assign s_awready = ~q.aw_got;
  assign s_wready = ~q.w_got;
  assign s_bvalid = q.bvalid;
  assign s_bresp = q.bresp;
  assign s_arready = ~q.rvalid;
  assign s_rvalid = q.rvalid;
  assign s_rdata = q.rdata;
  assign s_rresp = q.rresp;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_pin_low_hold: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_HOLD |-> rst_pin_n_oe)
    else $error("reset pin released during monitor hold");
  a_mon_fail_rst: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_RUN && mon_fail |=> q.st == RSM_ST_HOLD && sys_reset)
    else $error("monitor fail did not reset");
  a_no_delay: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_HOLD && core_above_rst |=> q.st == RSM_ST_RUN)
    else $error("monitor release delayed");
  a_por_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_DELAY ##1 q.st == RSM_ST_RUN |-> q.por_cause)
    else $error("cause flag not set after power-on");
  a_other_clear: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_RUN && !mon_fail && other_rst_req |=> !q.por_cause
    && $stable(q.mon_en))
    else $error("other reset mishandled cause or monitor");
  a_mon_restore: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_HOLD |-> q.mon_en && q.mon_sel)
    else $error("monitor not re-enabled");
  a_sleep_gate: assert property (@(posedge clk) disable iff (sys_rst)
    sleep_mode |-> !mon_fail)
    else $error("monitor reset active in sleep");
  a_flash_err: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_RUN && flash_prog_req && !q.mon_en |=> sys_reset)
    else $error("flash error did not reset");
  // a reset inside the window restarts the prescaler, so it drops the try
  a_wdt_div: assert property (@(posedge clk) disable iff (sys_rst || sys_reset)
    wdt_tick |=> !wdt_tick [*8] ##1 !wdt_tick [*3] ##1 wdt_tick)
    else $error("watchdog tick spacing wrong");
  a_wdt_en_rst: assert property (@(posedge clk) disable iff (sys_rst)
    wdt_enable != sys_reset)
    else $error("watchdog enable does not follow reset");
  a_pin_low_por: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_POR || q.st == RSM_ST_DELAY |-> rst_pin_n_oe)
    else $error("reset pin released during power-on");
  a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
    q.st == RSM_ST_RUN && !mon_fail && !flash_err && !other_rst_req
    && wr_go && q.aw_adr == `RSM_ADR_CAUSE && q.w_stb[0]
    |=> q.mon_sel == $past(q.w_dat[`RSM_BIT_POR]))
    else $error("cause write did not set monitor select");

endmodule : rsm_top

// >>> shared/rsm_defs.svh
// Operation
// - entering reset halts core, loads register defaults, parks pins, disables irqs
// - reset leaves ram untouched; stack pointer reinitialised
// - port latches all ones, open drain, weak pullups on during and after; code drives port_open_drain only during reset
// - power-on and monitor resets drive the reset pin low while in reset
// - leaving reset clears program counter, fetch at zero, internal oscillator; code drives int_osc_sel only during reset
// - after any reset watchdog enabled, clocked at system clock over twelve
// - hold reset until battery above threshold, then add release delay
// - power-on exit sets power-on cause flag
// - other resets clear power-on cause flag
// - power-on or power-fail reset enables and selects supply monitor
// - enabled, selected monitor holds reset while core supply below threshold
// - after power-fail reset cause flag reads one, ram invalid
// - only power-on and power-fail resets change monitor enable and select
// - sleep disables power-fail reset; wake restores last software value
// - early-warning bit clears below warning threshold and can interrupt
// - flash write or erase with monitor disabled causes flash-error reset
// - monitor reset has no power-on release delay
// - writing one to cause flag position selects monitor as reset source
// - selecting an unsettled monitor may cause a system reset
// - monitor enable is control bit 7; resets only when also selected
`ifndef RSM_DEFS_SVH
`define RSM_DEFS_SVH
`define RSM_CLK_HZ 40000000
`define RSM_DLY_LO_MS 3
`define RSM_DLY_MID_MS 7
`define RSM_DLY_HI_MS 15
`define RSM_MS_CYC (`RSM_CLK_HZ / 1000)
`define RSM_CNT_W 20
`define RSM_WDT_DIV 4'hc
`define RSM_PORT_RST 8'hff
`define RSM_PC_RST 16'h0000
`define RSM_ADR_CTRL 4'h0
`define RSM_ADR_CAUSE 4'h4
`define RSM_ADR_STAT 4'h8
`define RSM_BIT_MEN 7
`define RSM_BIT_OK 5
`define RSM_BIT_STAT 6
`define RSM_BIT_POR 1
`define RSM_BIT_SW 4
`define RSM_BIT_FLE 6
`define RSM_RESP_OK 2'b00
`define RSM_RESP_ERR 2'b10
`endif

// >>> shared/rsm_pkg.sv
package rsm_pkg;
  typedef enum logic [1:0] {
    RSM_LVL_LO,
    RSM_LVL_MID,
    RSM_LVL_HI
  } rsm_lvl_t;
  typedef enum logic [1:0] {
    RSM_ST_POR,
    RSM_ST_DELAY,
    RSM_ST_HOLD,
    RSM_ST_RUN
  } rsm_state_t;
endpackage : rsm_pkg

// >>> sim/rsm_supply_model.sv
module rsm_supply_model
(
  input wire logic clk,
  input wire logic bat_cmd,
  input wire logic core_cmd,
  input wire logic warn_cmd,
  input wire logic rst_pin_n_o,
  input wire logic rst_pin_n_oe,
  output logic bat_above_por,
  output logic core_above_rst,
  output logic core_above_warn,
  output logic rst_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // comparators settle one clock after the supply moves
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    bat_above_por <= bat_cmd;
    core_above_rst <= core_cmd;
    core_above_warn <= warn_cmd;
  end
  // pin has a pull-up, so a released pin reads high
  assign rst_pin = rst_pin_n_oe ? rst_pin_n_o : 1'b1;
endmodule : rsm_supply_model

// >>> sim/rsm_top_tb.sv
module rsm_top_tb
  import rsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  int dly[3] = '{20, 30, 40};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bat_cmd = 1'b0, core_cmd = 1'b1, warn_cmd = 1'b1;
  rsm_lvl_t bat_level = RSM_LVL_LO;
  logic other_rst_req = 1'b0, flash_prog_req = 1'b0, sleep_mode = 1'b0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic bat_above_por, core_above_rst, core_above_warn, rst_pin;
  logic sys_reset, rst_pin_n_o, rst_pin_n_oe, core_halt, ram_invalid;
  logic port_open_drain, weak_pullup_en, wdt_enable, wdt_tick, warn_irq;
  logic sp_reinit, irq_timer_disable, int_osc_sel;
  logic [15:0] program_counter;
  logic [7:0] port_latch;
  int miscompares = 0, comparisons = 0, cyc = 0, n;

  rsm_top #(.DLY_LO_CYC(20), .DLY_MID_CYC(30), .DLY_HI_CYC(40)) rsm_top_i
  (
    .clk, .sys_rst, .bat_above_por, .bat_level, .core_above_rst,
    .core_above_warn, .other_rst_req, .flash_prog_req, .sleep_mode,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .sys_reset,
    .rst_pin_n_o, .rst_pin_n_oe, .core_halt, .program_counter,
    .sp_reinit, .ram_invalid, .port_latch, .port_open_drain,
    .weak_pullup_en, .irq_timer_disable, .int_osc_sel, .wdt_enable,
    .wdt_tick, .warn_irq
  );
  rsm_supply_model rsm_supply_model_i
  (
    .clk, .bat_cmd, .core_cmd, .warn_cmd, .rst_pin_n_o, .rst_pin_n_oe,
    .bat_above_por, .core_above_rst, .core_above_warn, .rst_pin
  );

  initial
  begin
    forever
      #12.5 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      complete_run;
    end
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      if (s_bvalid)
        break;
    end
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task automatic rdm(input logic [3:0] a, input logic [31:0] m,
    input logic [31:0] e);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_arready)
        s_arvalid <= 1'b0;
      if (s_rvalid)
        break;
    end
    r = s_rresp;
    s_rready <= 1'b0;
    chk(s_rdata & m, e);
  endtask : rdm
  task automatic wait_rst(input logic v);
    n = 0;
    while (sys_reset !== v)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_rst
  task automatic pulse(input int k);
    @(posedge clk);
    other_rst_req <= (k == 0);
    flash_prog_req <= (k == 2);
    @(posedge clk);
    other_rst_req <= 1'b0;
    flash_prog_req <= 1'b0;
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic power_on;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      bat_cmd <= 1'b0;
      bat_level <= rsm_lvl_t'(i);
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clk);
      chk({rst_pin, core_halt, wdt_enable}, 3'b010);
      chk({port_latch, program_counter}, 24'hff0000);
      chk({port_open_drain, weak_pullup_en}, 2'b11);
      chk({sp_reinit, irq_timer_disable, int_osc_sel}, 3'b111);
      bat_cmd <= 1'b1;
      wait_rst(1'b0);
      chk(n >= dly[i] && n <= dly[i] + 5, 1);
      chk({rst_pin, wdt_enable, weak_pullup_en}, 3'b111);
      chk({sp_reinit, irq_timer_disable, int_osc_sel}, 3'b000);
    end
    rdm(4'h4, 32'h2, 32'h2);
    rdm(4'h0, 32'h80, 32'h80);
    rdm(4'h8, 32'h1, 32'h1);
    while (wdt_tick !== 1'b1)
      @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wdt_tick !== 1'b1);
    chk(n, 12);
  endtask : power_on
  // other, software and flash-error resets must keep the monitor state
  task automatic other_resets;
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 1)
        wr(4'h4, 32'h10);
      else
        pulse(k);
      wait_rst(1'b1);
      chk(n <= 4, 1);
      chk(rst_pin, 1'b1);
      wait_rst(1'b0);
      rdm(4'h0, 32'h80, 32'h0);
      rdm(4'h8, 32'h1, 32'h0);
      rdm(4'h4, 32'h2, 32'h0);
    end
  endtask : other_resets
  task automatic supply_fail;
    wr(4'h0, 32'h80);
    wr(4'h4, 32'h2);
    sleep_mode <= 1'b1;
    core_cmd <= 1'b0;
    repeat (20) @(posedge clk);
    chk(sys_reset, 1'b0);
    core_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    sleep_mode <= 1'b0;
    rdm(4'h8, 32'h1, 32'h1);
    core_cmd <= 1'b0;
    wait_rst(1'b1);
    chk(n <= 4, 1);
    repeat (50) @(posedge clk);
    chk({sys_reset, rst_pin}, 2'b10);
    chk(ram_invalid, 1'b1);
    core_cmd <= 1'b1;
    wait_rst(1'b0);
    chk(n < 10, 1);
    rdm(4'h4, 32'h2, 32'h2);
    rdm(4'h8, 32'h2, 32'h2);
    warn_cmd <= 1'b0;
    n = 0;
    while (warn_irq !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 8, 1);
    rdm(4'h0, 32'h60, 32'h40);
    rdm(4'hc, 32'hffffffff, 32'h0);
    chk(r, 2'b10);
    wr(4'hc, 32'h0);
    chk(r, 2'b10);
  endtask : supply_fail

  initial
  begin
    power_on;
    other_resets;
    supply_fail;
    complete_run;
  end
  task automatic complete_run;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
endmodule : rsm_top_tb
